// [design/dual_timer_control_mode.sv]
`timescale 1ns/1ns

module dual_timer_control_mode (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_val,
    input wire logic vector_timer_zero,
    input wire logic vector_timer_one,
    input wire logic vector_ext_irq_zero,
    input wire logic vector_ext_irq_one,
    input wire logic timer_zero_count_pin,
    input wire logic timer_one_count_pin,
    input wire logic ext_irq_zero_input,
    input wire logic ext_irq_one_input,
    input wire logic ext_irq_zero_polarity,
    input wire logic ext_irq_one_polarity,
    input wire logic timer_zero_clock_tick,
    input wire logic timer_one_clock_tick,
    output logic [7:0] timer_control,
    output logic timer_one_overflow
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [timer_pkg::PIN_COUNT-1:0] sync1;
        logic [timer_pkg::PIN_COUNT-1:0] sync2;
        logic [timer_pkg::PIN_COUNT-1:0] prev;
        logic [7:0] control;
        logic [7:0] mode;
        logic [7:0] zero_low;
        logic [7:0] zero_high;
        logic [7:0] one_low;
        logic [7:0] one_high;
        logic [7:0] rdata;
        logic one_pulse;
    } state_t;

    state_t q;
    state_t d;

    timer_pkg::timer_op_t mode_zero;
    timer_pkg::timer_op_t mode_one;
    logic split;
    logic x0_act;
    logic x1_act;
    logic x0_edge;
    logic x1_edge;
    logic run_zero;
    logic run_one;
    logic inc_zero;
    logic inc_one;
    logic inc_zero_high;
    logic ovf_zero;
    logic ovf_one;
    logic ovf_one_flag;
    logic bit_hit;
    logic [timer_pkg::PIN_COUNT-1:0] fall;
    logic [16:0] res_zero;
    logic [16:0] res_one;
    logic [8:0] res_split_low;
    logic [8:0] res_split_high;

    // ==========================================================
    // Counting helpers
    // ==========================================================
    // Returns {overflow, high, low} after one increment in the given mode.
    function automatic logic [16:0] step(
        input timer_pkg::timer_op_t m,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        logic [16:0] r;
        s13 = {1'b0, hi, lo[timer_pkg::LOW5_W-1:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (m)
            timer_pkg::MODE_13BIT:
                // The three upper low-byte bits are left untouched.
                r = {s13[13], s13[12:timer_pkg::LOW5_W],
                    lo[7:timer_pkg::LOW5_W], s13[timer_pkg::LOW5_W-1:0]};
            timer_pkg::MODE_16BIT:
                r = s16;
            timer_pkg::MODE_RELOAD8:
                r = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
            default:
                r = {1'b0, hi, lo};
        endcase
        return r;
    endfunction

    function automatic logic [8:0] inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction

    function automatic logic active_level(input logic level, input logic pol);
        return pol ? level : ~level;
    endfunction

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        d = q;
        // Edge decisions look only at the second and third stages.
        d.sync1 = {ext_irq_one_input, ext_irq_zero_input,
            timer_one_count_pin, timer_zero_count_pin};
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        fall = q.prev & ~q.sync2;

        mode_zero = timer_pkg::timer_op_t'(
            q.mode[timer_pkg::MOD_ZERO_MODE_LSB +: timer_pkg::MODE_W]);
        mode_one = timer_pkg::timer_op_t'(
            q.mode[timer_pkg::MOD_ONE_MODE_LSB +: timer_pkg::MODE_W]);
        split = (mode_zero == timer_pkg::MODE_SPLIT);

        x0_act = active_level(q.sync2[timer_pkg::PIN_X0], ext_irq_zero_polarity);
        x1_act = active_level(q.sync2[timer_pkg::PIN_X1], ext_irq_one_polarity);
        x0_edge = x0_act & ~active_level(q.prev[timer_pkg::PIN_X0], ext_irq_zero_polarity);
        x1_edge = x1_act & ~active_level(q.prev[timer_pkg::PIN_X1], ext_irq_one_polarity);

        run_zero = q.control[timer_pkg::CTL_ZERO_RUN] &
            (~q.mode[timer_pkg::MOD_ZERO_GATE] | x0_act);
        inc_zero = run_zero & (q.mode[timer_pkg::MOD_ZERO_CSEL] ?
            fall[timer_pkg::PIN_CNT_ZERO] : timer_zero_clock_tick);

        // While timer zero is split, timer one runs by mode alone, on
        // internal ticks only, and loses its flag to the split high byte.
        if (split)
        begin
            run_one = (mode_one != timer_pkg::MODE_SPLIT);
        end
        else
        begin
            run_one = q.control[timer_pkg::CTL_ONE_RUN] &
                (~q.mode[timer_pkg::MOD_ONE_GATE] | x1_act) &
                (mode_one != timer_pkg::MODE_SPLIT);
        end
        inc_one = run_one & ((q.mode[timer_pkg::MOD_ONE_CSEL] & ~split) ?
            fall[timer_pkg::PIN_CNT_ONE] : timer_one_clock_tick);
        inc_zero_high = split & q.control[timer_pkg::CTL_ONE_RUN] &
            timer_zero_clock_tick;

        res_zero = step(mode_zero, q.zero_low, q.zero_high);
        res_one = step(mode_one, q.one_low, q.one_high);
        res_split_low = inc8(q.zero_low);
        res_split_high = inc8(q.zero_high);

        ovf_zero = 1'b0;
        if (split)
        begin
            if (inc_zero)
            begin
                d.zero_low = res_split_low[7:0];
                ovf_zero = res_split_low[8];
            end
            if (inc_zero_high)
            begin
                d.zero_high = res_split_high[7:0];
            end
        end
        else if (inc_zero)
        begin
            {ovf_zero, d.zero_high, d.zero_low} = res_zero;
        end

        ovf_one = 1'b0;
        if (inc_one)
        begin
            {ovf_one, d.one_high, d.one_low} = res_one;
        end
        // The raw overflow of timer one stays usable by other peripherals.
        d.one_pulse = ovf_one;
        ovf_one_flag = split ? (inc_zero_high & res_split_high[8]) : ovf_one;

        // Software writes land after counting, so a store to a count byte always sticks.
        if (sfr_wr)
        begin
            case (sfr_addr)
                timer_pkg::ADDR_CONTROL: d.control = sfr_wdata;
                timer_pkg::ADDR_MODE: d.mode = sfr_wdata;
                timer_pkg::ADDR_ZERO_LOW: d.zero_low = sfr_wdata;
                timer_pkg::ADDR_ONE_LOW: d.one_low = sfr_wdata;
                timer_pkg::ADDR_ZERO_HIGH: d.zero_high = sfr_wdata;
                timer_pkg::ADDR_ONE_HIGH: d.one_high = sfr_wdata;
                default: d.control = d.control;
            endcase
        end
        bit_hit = sfr_bit_wr && (sfr_bit_addr[7:timer_pkg::BIT_SEL_W] ==
            timer_pkg::BIT_ADDR_BASE[7:timer_pkg::BIT_SEL_W]);
        if (bit_hit)
        begin
            d.control[sfr_bit_addr[timer_pkg::BIT_SEL_W-1:0]] = sfr_bit_val;
        end

        // Vectoring clears come first; hardware sets are applied last.
        if (vector_timer_zero)
        begin
            d.control[timer_pkg::CTL_ZERO_OVF] = 1'b0;
        end
        if (vector_timer_one)
        begin
            d.control[timer_pkg::CTL_ONE_OVF] = 1'b0;
        end
        if (vector_ext_irq_zero && q.control[timer_pkg::CTL_X0_TYPE])
        begin
            d.control[timer_pkg::CTL_X0_FLAG] = 1'b0;
        end
        if (vector_ext_irq_one && q.control[timer_pkg::CTL_X1_TYPE])
        begin
            d.control[timer_pkg::CTL_X1_FLAG] = 1'b0;
        end
        if (ovf_zero)
        begin
            d.control[timer_pkg::CTL_ZERO_OVF] = 1'b1;
        end
        if (ovf_one_flag)
        begin
            d.control[timer_pkg::CTL_ONE_OVF] = 1'b1;
        end
        if (q.control[timer_pkg::CTL_X0_TYPE] ? x0_edge : x0_act)
        begin
            d.control[timer_pkg::CTL_X0_FLAG] = 1'b1;
        end
        if (q.control[timer_pkg::CTL_X1_TYPE] ? x1_edge : x1_act)
        begin
            d.control[timer_pkg::CTL_X1_FLAG] = 1'b1;
        end

        if (sfr_rd)
        begin
            case (sfr_addr)
                timer_pkg::ADDR_CONTROL: d.rdata = q.control;
                timer_pkg::ADDR_MODE: d.rdata = q.mode;
                timer_pkg::ADDR_ZERO_LOW: d.rdata = q.zero_low;
                timer_pkg::ADDR_ONE_LOW: d.rdata = q.one_low;
                timer_pkg::ADDR_ZERO_HIGH: d.rdata = q.zero_high;
                timer_pkg::ADDR_ONE_HIGH: d.rdata = q.one_high;
                default: d.rdata = timer_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign sfr_rdata = q.rdata;
    assign timer_control = q.control;
    assign timer_one_overflow = q.one_pulse;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_ZERO_OVF_SET: assert property (ce && ovf_zero |=> q.control[timer_pkg::CTL_ZERO_OVF])
        else $error("Timer zero overflow did not set its flag.");

    AST_ONE_OVF_SET: assert property (ce && ovf_one_flag |=> q.control[timer_pkg::CTL_ONE_OVF])
        else $error("Timer one overflow did not set its flag.");

    AST_ZERO_HALT: assert property (ce && !q.control[timer_pkg::CTL_ZERO_RUN] && !split
        && !sfr_wr |=> $stable(q.zero_low) && $stable(q.zero_high))
        else $error("Timer zero counted while stopped.");

    AST_ZERO_GATE: assert property (ce && q.mode[timer_pkg::MOD_ZERO_GATE] && !x0_act
        && !split && !sfr_wr |=> $stable(q.zero_low) && $stable(q.zero_high))
        else $error("Gated timer zero counted with input inactive.");

    AST_ONE_GATE: assert property (ce && q.mode[timer_pkg::MOD_ONE_GATE] && !x1_act
        && !split && !sfr_wr |=> $stable(q.one_low) && $stable(q.one_high))
        else $error("Gated timer one counted with input inactive.");

    AST_RELOAD: assert property (ce && mode_zero == timer_pkg::MODE_RELOAD8 && inc_zero
        && q.zero_low == timer_pkg::BYTE_ONES && !sfr_wr
        |=> q.zero_low == $past(q.zero_high) && q.control[timer_pkg::CTL_ZERO_OVF])
        else $error("Reload mode did not refill the low byte.");

    AST_THIRTEEN: assert property (ce && mode_zero == timer_pkg::MODE_13BIT && inc_zero
        && q.zero_low[timer_pkg::LOW5_W-1:0] == timer_pkg::LOW5_ONES
        && q.zero_high == timer_pkg::BYTE_ONES && !sfr_wr
        |=> q.control[timer_pkg::CTL_ZERO_OVF] && q.zero_high == timer_pkg::RESET_BYTE)
        else $error("Thirteen-bit wrap went wrong.");

    AST_PIN_COUNT: assert property (ce && q.control[timer_pkg::CTL_ZERO_RUN]
        && q.mode[timer_pkg::MOD_ZERO_CSEL] && !q.mode[timer_pkg::MOD_ZERO_GATE]
        && mode_zero == timer_pkg::MODE_16BIT && q.prev[timer_pkg::PIN_CNT_ZERO]
        && !q.sync2[timer_pkg::PIN_CNT_ZERO] && !sfr_wr
        |=> q.zero_low == $past(q.zero_low) + timer_pkg::BYTE_ONE)
        else $error("Count pin falling edge missed.");

    AST_X0_EDGE: assert property (ce && q.control[timer_pkg::CTL_X0_TYPE] && x0_edge
        |=> q.control[timer_pkg::CTL_X0_FLAG])
        else $error("Irq zero edge not flagged.");

    AST_X1_LEVEL: assert property (ce && !q.control[timer_pkg::CTL_X1_TYPE] && x1_act
        |=> q.control[timer_pkg::CTL_X1_FLAG])
        else $error("Irq one level not flagged.");

    AST_X0_ACK: assert property (ce && vector_ext_irq_zero
        && q.control[timer_pkg::CTL_X0_TYPE] && !x0_edge && !sfr_wr && !sfr_bit_wr
        |=> !q.control[timer_pkg::CTL_X0_FLAG])
        else $error("Irq zero flag survived vectoring.");

    AST_RUN_BIT: assert property (ce && bit_hit && !sfr_wr
        && sfr_bit_addr[timer_pkg::BIT_SEL_W-1:0] == 3'(timer_pkg::CTL_ONE_RUN)
        |=> q.control[timer_pkg::CTL_ONE_RUN] == $past(sfr_bit_val))
        else $error("Run bit write did not take.");

endmodule // dual_timer_control_mode

// [design/timer_pkg.sv]
package timer_pkg;

    // ==========================================================
    // Register addresses on the special-function register bus
    // ==========================================================
    localparam logic [7:0] ADDR_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_ZERO_LOW = 8'h8A;
    localparam logic [7:0] ADDR_ONE_LOW = 8'h8B;
    localparam logic [7:0] ADDR_ZERO_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_ONE_HIGH = 8'h8D;
    localparam logic [7:0] BIT_ADDR_BASE = 8'h88;
    localparam int BIT_SEL_W = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // Control register bit positions
    // ==========================================================
    localparam int CTL_ONE_OVF = 7;
    localparam int CTL_ONE_RUN = 6;
    localparam int CTL_ZERO_OVF = 5;
    localparam int CTL_ZERO_RUN = 4;
    localparam int CTL_X1_FLAG = 3;
    localparam int CTL_X1_TYPE = 2;
    localparam int CTL_X0_FLAG = 1;
    localparam int CTL_X0_TYPE = 0;

    // ==========================================================
    // Mode register field positions
    // ==========================================================
    localparam int MOD_ONE_GATE = 7;
    localparam int MOD_ONE_CSEL = 6;
    localparam int MOD_ONE_MODE_LSB = 4;
    localparam int MOD_ZERO_GATE = 3;
    localparam int MOD_ZERO_CSEL = 2;
    localparam int MOD_ZERO_MODE_LSB = 0;
    localparam int MODE_W = 2;

    // ==========================================================
    // Counter geometry
    // ==========================================================
    localparam int LOW5_W = 5;
    localparam logic [4:0] LOW5_ONES = 5'h1F;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // ==========================================================
    // Synchronised input positions
    // ==========================================================
    localparam int PIN_CNT_ZERO = 0;
    localparam int PIN_CNT_ONE = 1;
    localparam int PIN_X0 = 2;
    localparam int PIN_X1 = 3;
    localparam int PIN_COUNT = 4;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD8 = 2'b10,
        MODE_SPLIT = 2'b11
    } timer_op_t;

endpackage

// [testbench/cpu_pin_model.sv]
`timescale 1ns/1ns

// ==========================================================
// CPU register bus and external pin side of the timer block
// ==========================================================
// Everything changes at the falling edge, so the block samples settled values.
module cpu_pin_model (
    input wire logic clk,
    output logic ce,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    output logic sfr_bit_wr,
    output logic [7:0] sfr_bit_addr,
    output logic sfr_bit_val,
    output logic [3:0] vec,
    output logic [3:0] pin,
    output logic [1:0] pol,
    output logic [1:0] tck
);
    initial
    begin
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, vec, tck} = '0;
        {sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
        ce = 1'b1;
        pin = 4'h3;
        pol = 2'h3;
    end

    // Idle bus lines carry the inverse of the last value, so stale data never passes.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask

    task automatic bw(input logic [2:0] b, input logic v);
        @(negedge clk);
        sfr_bit_addr = timer_pkg::BIT_ADDR_BASE + {5'h00, b};
        sfr_bit_val = v;
        sfr_bit_wr = 1'b1;
        @(negedge clk);
        sfr_bit_wr = 1'b0;
        sfr_bit_addr = ~sfr_bit_addr;
        sfr_bit_val = !v;
    endtask

    task automatic pulse(input int i);
        @(negedge clk);
        vec[i] = 1'b1;
        @(negedge clk);
        vec[i] = 1'b0;
    endtask

    task automatic tick(input int i, input int n);
        @(negedge clk);
        tck[i] = 1'b1;
        repeat (n) @(negedge clk);
        tck[i] = 1'b0;
    endtask

    // A pin change needs three edges through synchroniser and history; four are allowed.
    task automatic setp(input int i, input logic v);
        @(negedge clk);
        pin[i] = v;
        repeat (4) @(negedge clk);
    endtask
endmodule // cpu_pin_model

// [testbench/tb.sv]
`timescale 1ns/1ns

module tb;
    localparam logic [7:0] CT = timer_pkg::ADDR_CONTROL;
    localparam logic [7:0] MD = timer_pkg::ADDR_MODE;
    localparam logic [7:0] ZL = timer_pkg::ADDR_ZERO_LOW;
    localparam logic [7:0] ZH = timer_pkg::ADDR_ZERO_HIGH;
    localparam logic [7:0] OL = timer_pkg::ADDR_ONE_LOW;
    localparam logic [7:0] OH = timer_pkg::ADDR_ONE_HIGH;
    logic clk, rst_b, ce, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, timer_one_overflow, rd_pend;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr, timer_control, v, e, ty, fl;
    logic [3:0] vec, pin;
    logic [1:0] pol, tck;
    logic [15:0] exp_q[$];
    logic [15:0] ovf_q[$];
    int err_count, num_checks, cyc;
    integer seed;

    cpu_pin_model m (.clk, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_bit_wr,
        .sfr_bit_addr, .sfr_bit_val, .vec, .pin, .pol, .tck);

    dual_timer_control_mode dual_timer_control_mode_inst (.clk, .rst_b, .ce, .sfr_addr,
        .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_val,
        .vector_timer_zero(vec[0]), .vector_timer_one(vec[1]),
        .vector_ext_irq_zero(vec[2]), .vector_ext_irq_one(vec[3]),
        .timer_zero_count_pin(pin[0]), .timer_one_count_pin(pin[1]),
        .ext_irq_zero_input(pin[2]), .ext_irq_one_input(pin[3]),
        .ext_irq_zero_polarity(pol[0]), .ext_irq_one_polarity(pol[1]),
        .timer_zero_clock_tick(tck[0]), .timer_one_clock_tick(tck[1]),
        .timer_control, .timer_one_overflow);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // Checking
    // ==========================================================
    task automatic report_and_stop;
        // An overflow pulse that was announced but never seen is a mismatch too.
        if (ovf_q.size() != 0)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Masked-off bits are ignored; an unknown in the kept bits never matches.
    task automatic cmp(input logic [7:0] got, input logic [15:0] em);
        num_checks++;
        if ((got & em[15:8]) !== (em[7:0] & em[15:8]))
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, em[7:0]);
        end
    endtask

    always @(posedge clk) rd_pend <= sfr_rd && ce && rst_b;

    always @(negedge clk)
    begin
        if (rd_pend)
        begin
            cmp(sfr_rdata, exp_q.pop_front());
        end
    end

    // The overflow pulse and its flag come from the same edge, so both stand here.
    always @(negedge clk)
    begin
        if (timer_one_overflow === 1'b1)
        begin
            if (ovf_q.size() == 0)
            begin
                err_count++;
                $display("unexpected at %0t: got %h expected %h", $time, 1'b1, 1'b0);
            end
            else
            begin
                cmp(timer_control, ovf_q.pop_front());
            end
        end
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] a, input logic [7:0] x, input logic [7:0] mk = 8'hFF);
        exp_q.push_back({mk, x});
        m.acc(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        m.acc(1'b1, a, d);
    endtask

    task automatic wait4(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        rst_b = 1'b0;
        seed = 32'h7817;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        chk(CT, 8'h00);
        chk(MD, 8'h00);
        chk(ZL, 8'h00);
        chk(8'h80, timer_pkg::READ_UNMAPPED);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            wr(ZL, v);
            chk(ZL, v);
            wr(MD, ~v);
            chk(MD, ~v);
        end
        wr(MD, 8'h00);
        @(negedge clk);
        m.ce = 1'b0;
        wr(ZL, 8'h12);
        @(negedge clk);
        m.ce = 1'b1;
        chk(ZL, v);
        $display("test byte access done");
        e = 8'h00;
        for (int s = 1; s >= 0; s--)
        begin
            for (int b = 0; b < 8; b++)
            begin
                m.bw(b[2:0], s[0]);
                e[b] = s[0];
                chk(CT, e);
            end
        end
        $display("test bit access done");
        wr(MD, 8'h01);
        wr(ZL, 8'hFE);
        wr(ZH, 8'hFF);
        m.tick(0, 1);
        chk(ZL, 8'hFE);
        m.bw(3'd4, 1'b1);
        chk(ZL, 8'hFE);
        m.tick(0, 2);
        chk(ZL, 8'h00);
        chk(ZH, 8'h00);
        chk(CT, 8'h30);
        m.pulse(0);
        chk(CT, 8'h10);
        m.bw(3'd4, 1'b0);
        m.tick(0, 2);
        chk(ZL, 8'h00);
        wr(MD, 8'h00);
        wr(ZL, 8'h1F);
        wr(ZH, 8'hFF);
        m.bw(3'd4, 1'b1);
        m.tick(0, 1);
        chk(ZL, 8'h00, 8'h1F);
        chk(CT, 8'h30);
        wr(CT, 8'h00);
        wr(MD, 8'h02);
        wr(ZH, 8'h80);
        wr(ZL, 8'hFF);
        m.bw(3'd4, 1'b1);
        m.tick(0, 1);
        chk(ZL, 8'h80);
        chk(ZH, 8'h80);
        chk(CT, 8'h30);
        wr(CT, 8'h00);
        $display("test modes done");
        wr(MD, 8'h09);
        wr(ZL, 8'h00);
        m.bw(3'd4, 1'b1);
        m.tick(0, 3);
        chk(ZL, 8'h00);
        m.setp(2, 1'b1);
        m.tick(0, 3);
        chk(ZL, 8'h03);
        chk(CT, 8'h12);
        m.setp(2, 1'b0);
        wr(CT, 8'h00);
        $display("test gate done");
        for (int i = 0; i < 2; i++)
        begin
            ty = 8'h01 << (2 * i);
            fl = 8'h02 << (2 * i);
            wr(CT, ty);
            m.setp(2 + i, 1'b1);
            m.setp(2 + i, 1'b0);
            chk(CT, ty | fl);
            m.pulse(2 + i);
            chk(CT, ty);
            wr(CT, 8'h00);
            @(negedge clk);
            m.pol[i] = 1'b0;
            wait4(4);
            m.pulse(2 + i);
            chk(CT, fl);
            wr(CT, 8'h00);
            chk(CT, fl);
            @(negedge clk);
            m.pol[i] = 1'b1;
            wait4(4);
            wr(CT, 8'h00);
            chk(CT, 8'h00);
        end
        $display("test external irq done");
        wr(MD, 8'h60);
        wr(OH, 8'h33);
        wr(OL, 8'hFF);
        m.bw(3'd6, 1'b1);
        ovf_q.push_back(16'hFFC0);
        m.setp(1, 1'b0);
        m.setp(1, 1'b1);
        chk(OL, 8'h33);
        chk(CT, 8'hC0);
        m.pulse(1);
        chk(CT, 8'h40);
        wr(MD, 8'h30);
        wr(OL, 8'h00);
        m.tick(1, 2);
        chk(OL, 8'h00);
        wr(MD, 8'h10);
        m.tick(1, 2);
        chk(OL, 8'h02);
        wr(MD, 8'h90);
        m.tick(1, 2);
        chk(OL, 8'h02);
        m.setp(3, 1'b1);
        m.tick(1, 2);
        chk(OL, 8'h04);
        m.setp(3, 1'b0);
        wr(CT, 8'h40);
        m.bw(3'd6, 1'b0);
        m.tick(1, 2);
        chk(OL, 8'h04);
        $display("test timer one done");
        v = 8'($random(seed));
        wr(MD, 8'h05);
        wr(ZL, v);
        m.bw(3'd4, 1'b1);
        m.setp(0, 1'b0);
        m.setp(0, 1'b1);
        chk(ZL, v + 8'h01);
        m.bw(3'd4, 1'b0);
        $display("test count pin done");
        wr(MD, 8'h03);
        wr(ZH, 8'hFF);
        m.bw(3'd6, 1'b1);
        m.tick(0, 1);
        chk(ZH, 8'h00);
        chk(CT, 8'hC0);
        $display("test split done");
        wait4(2);
        report_and_stop();
    end
endmodule // tb
